// ===== verilog/drb_rx_buffer_ctrl.sv
// Control, status and configuration for the data cell receive buffer.
// Assumes a 16-bit register port on CLK and a cell writer that pulses CELL_DONE.
//
// Notes on behaviour
// - While disabled the write pointer is held at zero and finished cells are dropped.
// - While enabled, incoming cells are accepted and stored in the buffer.
// - The summary service output is set while any flag is set together with its enable.
// - The overrun flag is latched when the advanced write pointer meets the read pointer.
// - The arrival flag is latched each time one cell has been written.
// - The half-full flag is latched when the pointers show half the capacity unread.
// - The rollover flag is latched when the cell counter wraps past its maximum.
// - Each flag stays set until software writes a zero to its bit.
// - The size field picks 16, 32, 64 or 128 cells.
// - The base field gives word address bits 19:9 of the buffer, low bits zero.
// - The write pointer advances after each cell write, wrapping within the size.
// - The read pointer starts at the last location and names the cell last read.
// - A 16-bit count of received cells is kept and readable.
`timescale 1ns/100ps
`include "drb_consts.svh"

module drb_rx_buffer_ctrl (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Register port
    input wire drb_pkg::drb_bus_req_t BUS_REQ,
    output drb_pkg::drb_bus_rsp_t BUS_RSP,
    // Cell path
    input wire logic CELL_DONE,
    output logic CELL_ACCEPT,
    output logic [19:0] CELL_ADDR,
    // Service summary
    output logic DATA_RX_SUMMARY_SERVICE
);

    logic [4:0] ctrl_q;
    logic [12:0] cfg_q;
    logic [12:0] cfg_d;
    logic [6:0] wp_q;
    logic [6:0] wp_d;
    logic [6:0] rp_q;
    logic [15:0] cnt_q;
    logic [19:0] addr_q;
    drb_pkg::drb_bus_rsp_t rsp_q;
    logic summary_q;
    drb_pkg::drb_flags_t flags;
    drb_pkg::drb_flags_t flag_set;
    drb_pkg::drb_flags_t flag_clr;
    drb_pkg::drb_flags_t flag_en;
    drb_pkg::drb_size_t size_sel;
    logic [6:0] mask;
    logic [6:0] wp_inc;
    logic [6:0] rp_m;
    logic [6:0] unread_after;
    logic cell_take;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_cfg;
    logic wr_rp;

    function automatic logic hit(input drb_pkg::drb_bus_req_t req, input logic [15:0] off);
        hit = (req.addr == off);
    endfunction

    // Pointer wrap mask for the selected capacity
    function automatic logic [6:0] size_mask(input drb_pkg::drb_size_t sel);
        unique case (sel)
            drb_pkg::DRB_SZ16: size_mask = 7'h0f;
            drb_pkg::DRB_SZ32: size_mask = 7'h1f;
            drb_pkg::DRB_SZ64: size_mask = 7'h3f;
            drb_pkg::DRB_SZ128: size_mask = 7'h7f;
        endcase
    endfunction

    assign wr_ctrl = BUS_REQ.wr && hit(BUS_REQ, `DRB_OFF_CONTROL);
    assign wr_stat = BUS_REQ.wr && hit(BUS_REQ, `DRB_OFF_STATUS);
    assign wr_cfg = BUS_REQ.wr && hit(BUS_REQ, `DRB_OFF_CONFIG);
    assign wr_rp = BUS_REQ.wr && hit(BUS_REQ, `DRB_OFF_READ_PTR);

    assign size_sel = drb_pkg::drb_size_t'(cfg_q[`DRB_CFG_SIZE_MSB:`DRB_CFG_SIZE_LSB]);
    assign mask = size_mask(size_sel);
    assign rp_m = rp_q & mask;
    assign wp_inc = (wp_q + 7'h01) & mask;
    // Read pointer names the last cell read, so unread cells sit after it
    assign unread_after = (wp_inc - rp_m - 7'h01) & mask;
    assign cell_take = CELL_DONE && ctrl_q[`DRB_CTRL_ENABLE_BIT];

    // Control register, reserved bits not stored
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= `DRB_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= BUS_REQ.wdata[4:0];
        end
    end

    always_comb begin
        cfg_d = cfg_q;
        if (wr_cfg) begin
            cfg_d = BUS_REQ.wdata[12:0];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_q <= `DRB_CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Write pointer
    always_comb begin
        wp_d = wp_q;
        if (!ctrl_q[`DRB_CTRL_ENABLE_BIT]) begin
            wp_d = `DRB_WP_RESET;
        end else if (CELL_DONE) begin
            wp_d = wp_inc;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wp_q <= `DRB_WP_RESET;
        end else begin
            wp_q <= wp_d;
        end
    end

    // Read pointer, moved only by software
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rp_q <= `DRB_RP_RESET;
        end else if (wr_rp) begin
            rp_q <= BUS_REQ.wdata[6:0];
        end
    end

    // Received cell counter, free running with wrap
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= `DRB_CNT_RESET;
        end else if (cell_take) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Cell address follows next pointer and base so the writer never sees a stale slot
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            addr_q <= 20'h00000;
        end else begin
            addr_q <= {cfg_d[`DRB_CFG_BASE_MSB:`DRB_CFG_BASE_LSB], 9'h000} |
                      {8'h00, wp_d, 5'h00};
        end
    end

    assign flag_set.overrun = cell_take && (wp_inc == rp_m);
    assign flag_set.arrival = cell_take;
    // Exact half is caught on the write that reaches it
    assign flag_set.half_full = cell_take && (unread_after == ((mask >> 1) + 7'h01));
    assign flag_set.rollover = cell_take && (cnt_q == `DRB_CNT_MAX);

    assign flag_clr.overrun = wr_stat && !BUS_REQ.wdata[`DRB_STAT_OVERRUN_BIT];
    assign flag_clr.arrival = wr_stat && !BUS_REQ.wdata[`DRB_STAT_ARRIVAL_BIT];
    assign flag_clr.half_full = wr_stat && !BUS_REQ.wdata[`DRB_STAT_HALF_BIT];
    assign flag_clr.rollover = wr_stat && !BUS_REQ.wdata[`DRB_STAT_ROLL_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < `DRB_NUM_FLAGS; gi = gi + 1) begin : g_flag
            drb_sticky_flag u_flag (
                .clk(CLK),
                .rst_n(RST_N),
                .set(flag_set[gi]),
                .clr(flag_clr[gi]),
                .flag(flags[gi])
            );
        end
    endgenerate

    assign flag_en = drb_pkg::drb_flags_t'(ctrl_q[`DRB_CTRL_ROLL_SE_BIT:`DRB_CTRL_OVERRUN_SE_BIT]);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            summary_q <= 1'b0;
        end else begin
            summary_q <= |(flags & flag_en);
        end
    end

    // Register reads, registered, unmapped reads return zero
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rsp_q <= '0;
        end else begin
            rsp_q.rvalid <= BUS_REQ.rd;
            rsp_q.rdata <= 16'h0000;
            if (BUS_REQ.rd) begin
                if (hit(BUS_REQ, `DRB_OFF_CONTROL)) begin
                    rsp_q.rdata <= {11'h000, ctrl_q};
                end else if (hit(BUS_REQ, `DRB_OFF_STATUS)) begin
                    rsp_q.rdata <= {11'h000, flags, 1'b0};
                end else if (hit(BUS_REQ, `DRB_OFF_CONFIG)) begin
                    rsp_q.rdata <= {3'h0, cfg_q};
                end else if (hit(BUS_REQ, `DRB_OFF_WRITE_PTR)) begin
                    rsp_q.rdata <= {9'h000, wp_q};
                end else if (hit(BUS_REQ, `DRB_OFF_READ_PTR)) begin
                    rsp_q.rdata <= {9'h000, rp_q};
                end else if (hit(BUS_REQ, `DRB_OFF_CELL_COUNT)) begin
                    rsp_q.rdata <= cnt_q;
                end
            end
        end
    end

    assign BUS_RSP = rsp_q;
    assign CELL_ACCEPT = ctrl_q[`DRB_CTRL_ENABLE_BIT];
    assign CELL_ADDR = addr_q;
    assign DATA_RX_SUMMARY_SERVICE = summary_q;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    property p_disabled_wp_zero;
        !ctrl_q[`DRB_CTRL_ENABLE_BIT] |=> (wp_q == 7'h00);
    endproperty
    a_disabled_wp_zero: assert property (p_disabled_wp_zero) else $error("write pointer not held at zero");

    property p_disabled_drop;
        (CELL_DONE && !CELL_ACCEPT) |-> !flag_set.arrival ##1 (cnt_q == $past(cnt_q));
    endproperty
    a_disabled_drop: assert property (p_disabled_drop) else $error("cell counted while disabled");

    property p_accept_count;
        (CELL_DONE && CELL_ACCEPT) |=> (cnt_q == $past(cnt_q) + 16'h0001);
    endproperty
    a_accept_count: assert property (p_accept_count) else $error("accepted cell not counted");

    property p_wp_advance;
        (CELL_DONE && CELL_ACCEPT) |=> (wp_q == (($past(wp_q) + 7'h01) & $past(mask)));
    endproperty
    a_wp_advance: assert property (p_wp_advance) else $error("write pointer did not advance");

    property p_addr_tracks_wp;
        ##1 (CELL_ADDR[11:5] == ($past(wp_d) | {$past(cfg_d[4:2]), 4'h0})) && (CELL_ADDR[4:0] == 5'h00) &&
            (CELL_ADDR[19:12] == $past(cfg_d[12:5]));
    endproperty
    a_addr_tracks_wp: assert property (p_addr_tracks_wp) else $error("cell address wrong");

    property p_overrun;
        (cell_take && (wp_inc == rp_m)) |=> flags.overrun;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not latched");

    property p_arrival;
        cell_take |=> flags.arrival;
    endproperty
    a_arrival: assert property (p_arrival) else $error("arrival not latched");

    property p_half_full;
        (cell_take && (unread_after == ((mask >> 1) + 7'h01))) |=> flags.half_full;
    endproperty
    a_half_full: assert property (p_half_full) else $error("half full not latched");

    property p_ctrl_write;
        wr_ctrl |=> (CELL_ACCEPT == $past(BUS_REQ.wdata[0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("enable bit not taken");

    property p_rollover;
        (cell_take && (cnt_q == 16'hffff)) |=> flags.rollover && (cnt_q == 16'h0000);
    endproperty
    a_rollover: assert property (p_rollover) else $error("rollover not latched");

    property p_flag_clear;
        (wr_stat && !BUS_REQ.wdata[`DRB_STAT_ARRIVAL_BIT] && !cell_take) |=> !flags.arrival;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("arrival flag not cleared");

    property p_flag_holds;
        (flags.overrun && !flag_clr.overrun) |=> flags.overrun;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("overrun flag dropped");

    property p_summary;
        (flags.half_full && ctrl_q[`DRB_CTRL_HALF_SE_BIT]) |=> DATA_RX_SUMMARY_SERVICE;
    endproperty
    a_summary: assert property (p_summary) else $error("summary not raised");

    property p_summary_low;
        !(|(flags & flag_en)) |=> !DATA_RX_SUMMARY_SERVICE;
    endproperty
    a_summary_low: assert property (p_summary_low) else $error("summary raised without cause");

    property p_reserved_zero;
        (BUS_REQ.rd && hit(BUS_REQ, `DRB_OFF_STATUS)) |=> (BUS_RSP.rdata[15:5] == 11'h000) && !BUS_RSP.rdata[0];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits set");

endmodule

// ===== inc/drb_consts.svh
// Constants for the data cell receive buffer control block.
// Assumes a 16-bit register port with byte addresses as printed.
`ifndef DRB_CONSTS_SVH
`define DRB_CONSTS_SVH

// Register byte addresses
`define DRB_OFF_CONTROL 16'h2020
`define DRB_OFF_STATUS 16'h2022
`define DRB_OFF_CONFIG 16'h2024
`define DRB_OFF_WRITE_PTR 16'h2026
`define DRB_OFF_READ_PTR 16'h2028
`define DRB_OFF_CELL_COUNT 16'h202a

// Control register fields
`define DRB_CTRL_ENABLE_BIT 0
`define DRB_CTRL_OVERRUN_SE_BIT 1
`define DRB_CTRL_ARRIVAL_SE_BIT 2
`define DRB_CTRL_HALF_SE_BIT 3
`define DRB_CTRL_ROLL_SE_BIT 4
`define DRB_CTRL_RESET 5'h00

// Status register fields, bit 0 reserved
`define DRB_STAT_OVERRUN_BIT 1
`define DRB_STAT_ARRIVAL_BIT 2
`define DRB_STAT_HALF_BIT 3
`define DRB_STAT_ROLL_BIT 4
`define DRB_NUM_FLAGS 4

// Configuration register fields
`define DRB_CFG_SIZE_LSB 0
`define DRB_CFG_SIZE_MSB 1
`define DRB_CFG_BASE_LSB 2
`define DRB_CFG_BASE_MSB 12
`define DRB_CFG_RESET 13'h0000

// Pointer and counter reset values
`define DRB_WP_RESET 7'h00
`define DRB_RP_RESET 7'h7f
`define DRB_CNT_RESET 16'h0000
`define DRB_CNT_MAX 16'hffff

// External memory layout: 32 words per cell, base fills address bits 19:9
`define DRB_WORDS_PER_CELL_LOG2 5
`define DRB_BASE_SHIFT 9

`endif

// ===== inc/drb_pkg.sv
// Types for the data cell receive buffer control block.
// Assumes drb_consts.svh supplies the numeric constants.
package drb_pkg;

    // Register port request, one access per cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } drb_bus_req_t;

    // Register port answer
    typedef struct packed {
        logic rvalid;
        logic [15:0] rdata;
    } drb_bus_rsp_t;

    // Buffer capacity codes, in field order
    typedef enum logic [1:0] {
        DRB_SZ16,
        DRB_SZ32,
        DRB_SZ64,
        DRB_SZ128
    } drb_size_t;

    // Latched flags, high index first
    typedef struct packed {
        logic rollover;
        logic half_full;
        logic arrival;
        logic overrun;
    } drb_flags_t;

endpackage

// ===== verilog/drb_sticky_flag.sv
// One latched status flag that hardware sets and software clears.
// Assumes set and clear are single-cycle strobes on CLK.
`timescale 1ns/100ps
`include "drb_consts.svh"

module drb_sticky_flag (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Events
    input wire logic set,
    input wire logic clr,
    // Flag
    output logic flag
);

    logic flag_q;

    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end

    assign flag = flag_q;

endmodule

// ===== test/drb_cell_src.sv
// Upstream cell writer model: one done strobe per finished cell.
// Assumes the bench loads start and count on the falling edge.
`timescale 1ns/100ps

module drb_cell_src (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench control
    input wire logic start,
    input wire logic [16:0] count,
    input wire logic force_send,
    // Cell path
    input wire logic accept,
    output logic cell_done,
    output logic busy
);
    logic [16:0] left_q;

    assign busy = (left_q != 17'h00000) || cell_done;

    // Falling edge, so the block samples a settled strobe
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_q <= 17'h00000;
            cell_done <= 1'b0;
        end else if (start) begin
            left_q <= count;
            cell_done <= 1'b0;
        end else if (left_q != 17'h00000 && (accept || force_send)) begin
            // Forcing ignores accept, to show that a disabled block drops cells
            left_q <= left_q - 17'h00001;
            cell_done <= 1'b1;
        end else begin
            cell_done <= 1'b0;
        end
    end
endmodule

// ===== test/test_drb_rx_buffer_ctrl.sv
// Self-checking bench for the receive buffer control block.
// Assumes the cell source model is the only writer of cells.
`timescale 1ns/100ps
`include "drb_consts.svh"

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end

module test_drb_rx_buffer_ctrl;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    drb_pkg::drb_bus_req_t req = '0;
    drb_pkg::drb_bus_rsp_t rsp;
    logic start = 1'b0;
    logic force_send = 1'b0;
    logic [16:0] count = 17'h00000;
    logic cell_done, accept, busy, summary;
    logic [19:0] cell_addr;
    logic [15:0] rd_val;
    int err_total = 0;
    int n_checks = 0;
    int acc = 0;

    drb_rx_buffer_ctrl i_dut (.CLK(clk), .RST_N(rst_n), .BUS_REQ(req), .BUS_RSP(rsp),
        .CELL_DONE(cell_done), .CELL_ACCEPT(accept), .CELL_ADDR(cell_addr),
        .DATA_RX_SUMMARY_SERVICE(summary));

    drb_cell_src i_src (.clk(clk), .rst_n(rst_n), .start(start), .count(count),
        .force_send(force_send), .accept(accept), .cell_done(cell_done), .busy(busy));

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(negedge clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a);
        @(negedge clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(negedge clk);
        req.rd <= 1'b0;
        `CHK("rvalid", 1'b1, rsp.rvalid)
        rd_val = rsp.rdata;
    endtask

    task automatic chk_rd(input string nm, input logic [15:0] a, input logic [15:0] e);
        rd(a);
        `CHK(nm, e, rd_val)
    endtask

    task automatic send(input int n, input logic frc);
        @(negedge clk);
        start <= 1'b1;
        count <= 17'(n);
        force_send <= frc;
        @(negedge clk);
        start <= 1'b0;
        repeat (2) @(negedge clk);
        while (busy === 1'b1) @(negedge clk);
        // Flags land one cycle after the strobe, the summary one more
        repeat (3) @(negedge clk);
        if (!frc) acc += n;
    endtask

    task automatic t_reset();
        chk_rd("control", `DRB_OFF_CONTROL, 16'h0000);
        chk_rd("status", `DRB_OFF_STATUS, 16'h0000);
        chk_rd("config", `DRB_OFF_CONFIG, 16'h0000);
        chk_rd("write_ptr", `DRB_OFF_WRITE_PTR, 16'h0000);
        chk_rd("read_ptr", `DRB_OFF_READ_PTR, 16'h007f);
        chk_rd("count", `DRB_OFF_CELL_COUNT, 16'h0000);
        wr(`DRB_OFF_CELL_COUNT, 16'h1234);
        chk_rd("count_ro", `DRB_OFF_CELL_COUNT, 16'h0000);
        chk_rd("unmapped", 16'h2030, 16'h0000);
        `CHK("accept_off", 1'b0, accept)
    endtask

    task automatic t_disabled();
        send(3, 1'b1);
        chk_rd("write_ptr", `DRB_OFF_WRITE_PTR, 16'h0000);
        chk_rd("count", `DRB_OFF_CELL_COUNT, 16'h0000);
        chk_rd("status", `DRB_OFF_STATUS, 16'h0000);
        `CHK("cell_addr", 20'h00000, cell_addr)
    endtask

    task automatic t_cells();
        wr(`DRB_OFF_CONFIG, 16'h000c);
        wr(`DRB_OFF_CONTROL, 16'hffff);
        chk_rd("control", `DRB_OFF_CONTROL, 16'h001f);
        `CHK("accept_on", 1'b1, accept)
        send(1, 1'b0);
        chk_rd("write_ptr", `DRB_OFF_WRITE_PTR, 16'h0001);
        chk_rd("count", `DRB_OFF_CELL_COUNT, 16'h0001);
        chk_rd("status", `DRB_OFF_STATUS, 16'h0004);
        `CHK("cell_addr", 20'h00620, cell_addr)
        `CHK("summary_on", 1'b1, summary)
        wr(`DRB_OFF_CONTROL, 16'h001b);
        repeat (3) @(negedge clk);
        `CHK("summary_masked", 1'b0, summary)
        wr(`DRB_OFF_CONTROL, 16'h001f);
        // Read pointer 7f masked to f, so half full falls on write pointer 8
        send(6, 1'b0);
        chk_rd("status", `DRB_OFF_STATUS, 16'h0004);
        send(1, 1'b0);
        chk_rd("status", `DRB_OFF_STATUS, 16'h000c);
        wr(`DRB_OFF_STATUS, 16'h0008);
        chk_rd("status", `DRB_OFF_STATUS, 16'h0008);
        send(6, 1'b0);
        chk_rd("status", `DRB_OFF_STATUS, 16'h000c);
        send(1, 1'b0);
        chk_rd("status", `DRB_OFF_STATUS, 16'h000e);
        send(1, 1'b0);
        chk_rd("write_ptr", `DRB_OFF_WRITE_PTR, 16'h0000);
        `CHK("cell_addr", 20'h00600, cell_addr)
        wr(`DRB_OFF_READ_PTR, 16'hff85);
        chk_rd("read_ptr", `DRB_OFF_READ_PTR, 16'h0005);
        wr(`DRB_OFF_STATUS, 16'h0000);
        chk_rd("status", `DRB_OFF_STATUS, 16'h0000);
    endtask

    task automatic t_sizes();
        for (int s = 0; s < 4; s++) begin
            wr(`DRB_OFF_CONTROL, 16'h0000);
            chk_rd("write_ptr", `DRB_OFF_WRITE_PTR, 16'h0000);
            wr(`DRB_OFF_CONFIG, 16'he040 | 16'(s));
            chk_rd("config", `DRB_OFF_CONFIG, 16'h0040 | 16'(s));
            wr(`DRB_OFF_CONTROL, 16'h0001);
            send(16 << s, 1'b0);
            chk_rd("wrap", `DRB_OFF_WRITE_PTR, 16'h0000);
            send(1, 1'b0);
            chk_rd("write_ptr", `DRB_OFF_WRITE_PTR, 16'h0001);
            `CHK("cell_addr", 20'h02020, cell_addr)
        end
    endtask

    task automatic t_rollover();
        chk_rd("count", `DRB_OFF_CELL_COUNT, 16'(acc));
        wr(`DRB_OFF_STATUS, 16'h0000);
        send(65535 - acc, 1'b0);
        chk_rd("count_max", `DRB_OFF_CELL_COUNT, 16'hffff);
        rd(`DRB_OFF_STATUS);
        `CHK("rollover_early", 1'b0, rd_val[`DRB_STAT_ROLL_BIT])
        send(1, 1'b0);
        chk_rd("count_wrap", `DRB_OFF_CELL_COUNT, 16'h0000);
        rd(`DRB_OFF_STATUS);
        `CHK("rollover", 1'b1, rd_val[`DRB_STAT_ROLL_BIT])
    endtask

    initial begin
        forever #5 clk = ~clk;
    end

    // Whole run is near 66k cycles
    initial begin
        #900000;
        err_total++;
        complete_run();
    end

    initial begin
        repeat (16) @(negedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_disabled();
        t_cells();
        t_sizes();
        t_rollover();
        complete_run();
    end
endmodule
